// >>> bench/csl_cas_model.sv
// Memory cassette model answering the block's word reads.
// Assumes data is wanted the cycle after each read pulse.
`timescale 1ns/1ps
module csl_cas_model (
  // Clock.
  input  wire        sys_clk,
  // Read port.
  input  wire        cas_rd,
  input  wire [7:0]  cas_addr,
  output reg  [15:0] cas_data,
  // Reads seen.
  output reg  [7:0]  rd_count
);
  initial begin
    cas_data = 16'h0000;
    rd_count = 8'h00;
  end
  // Data is inverted outside the answer cycle so a late capture shows.
  always @(posedge sys_clk) begin
    if (cas_rd) begin
      cas_data <= {8'hC5, cas_addr};
      rd_count <= rd_count + 8'h01;
    end else begin
      cas_data <= ~cas_data;
    end
  end
endmodule // csl_cas_model

// >>> bench/csl_core_monitor.sv
// Checker for the strap and lamp block, bound to csl_core.
// Assumes the short blink and hold counts that the bench sets.
`timescale 1ns/1ps
module csl_core_monitor #(
  parameter integer BLINK_CYCLES     = 4,
  parameter integer LINK_ACTIVITY_LAMP_HOLD_CYCLES = 8
) (
  // Clock and reset.
  input wire        sys_clk,
  input wire        rst_n,
  // Register read side.
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  // Activity and cassette.
  input wire        periph_active,
  input wire        serial_active,
  input wire        cas_rd,
  input wire [7:0]  cas_addr,
  // Modes and outputs.
  input wire        expins_req,
  input wire        expins_grant,
  input wire        expins_refused,
  input wire        outputs_enable,
  input wire        console_english,
  input wire        console_expansion_flag,
  // Lamps.
  input wire        run_lamp,
  input wire        error_lamp,
  input wire        output_inhibit_lamp,
  input wire        link_activity_lamp
);
  reg [3:0] up_cnt_reg;
  reg [4:0] idle_cnt_reg;
  // Counters saturate so long runs never wrap into false passes.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_cnt_reg   <= 4'h0;
      idle_cnt_reg <= 5'h00;
    end else begin
      if (up_cnt_reg != 4'hF)
        up_cnt_reg <= up_cnt_reg + 4'h1;
      if (periph_active || serial_active)
        idle_cnt_reg <= 5'h00;
      else if (idle_cnt_reg != 5'h1F)
        idle_cnt_reg <= idle_cnt_reg + 5'h01;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence act_run; (periph_active || serial_active) [*8]; endsequence
  sequence err_steady; error_lamp [*6]; endsequence
  sequence cas_step; cas_rd ##1 !cas_rd ##1 cas_rd; endsequence
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  AST_EXP_ANSWER: assert property (
    expins_req |=> (expins_grant ^ expins_refused))
    else $error("expansion request not answered");
  AST_EXP_IDLE: assert property (
    !expins_req |=> !expins_grant && !expins_refused)
    else $error("expansion answer without request");
  AST_STRAP_HOLD: assert property (
    up_cnt_reg >= 4'h6 |->
      $stable(console_english) && $stable(console_expansion_flag))
    else $error("strap outputs changed after capture");
  AST_INH_OUT: assert property (
    output_inhibit_lamp |-> !outputs_enable)
    else $error("outputs on while inhibited");
  AST_RUN_OUT: assert property (
    run_lamp |-> outputs_enable || output_inhibit_lamp)
    else $error("run lamp with outputs off");
  AST_FATAL: assert property (
    err_steady |-> !run_lamp && !outputs_enable)
    else $error("fatal error left run or outputs on");
  AST_LINK_FLASH: assert property (
    act_run |-> ##[1:5] $changed(link_activity_lamp))
    else $error("link lamp not flashing");
  AST_LINK_IDLE: assert property (
    idle_cnt_reg > LINK_ACTIVITY_LAMP_HOLD_CYCLES + 4 |-> !link_activity_lamp)
    else $error("link lamp lit while idle");
  AST_CAS_STEP: assert property (
    cas_step |-> cas_addr == $past(cas_addr, 2) + 8'h01)
    else $error("cassette address did not step");
  AST_CAS_PULSE: assert property (cas_rd |=> !cas_rd)
    else $error("cassette read longer than one cycle");
endmodule // csl_core_monitor

bind csl_core csl_core_monitor #(.BLINK_CYCLES(BLINK_CYCLES),
  .LINK_ACTIVITY_LAMP_HOLD_CYCLES(LINK_ACTIVITY_LAMP_HOLD_CYCLES)) u_mon (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .periph_active(periph_active),
  .serial_active(serial_active), .cas_rd(cas_rd), .cas_addr(cas_addr),
  .expins_req(expins_req), .expins_grant(expins_grant),
  .expins_refused(expins_refused), .outputs_enable(outputs_enable),
  .console_english(console_english),
  .console_expansion_flag(console_expansion_flag),
  .run_lamp(run_lamp), .error_lamp(error_lamp),
  .output_inhibit_lamp(output_inhibit_lamp),
  .link_activity_lamp(link_activity_lamp));

// >>> bench/csl_core_tb.sv
// Self-checking bench for the strap and lamp block.
// Assumes short blink, hold and cassette counts; drives every pin.
`timescale 1ns/1ps
module csl_core_tb;
  reg         sys_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [5:0]  reg_addr = 6'h00;
  reg  [31:0] reg_wdata = 32'h0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [5:0]  strap_pins = 6'h00;
  reg         periph_active = 1'b0;
  reg         serial_active = 1'b0;
  reg         expins_req = 1'b0;
  wire [31:0] reg_rdata;
  wire        cas_rd, expins_grant, expins_refused, outputs_enable;
  wire        console_english, console_expansion_flag;
  wire        run_lamp, error_lamp, output_inhibit_lamp;
  wire        link_activity_lamp;
  wire [7:0]  cas_addr, serial_frame, cas_count;
  wire [15:0] cas_data;
  integer     err_count = 0;
  integer     samples_checked = 0;
  integer     i, n;
  reg  [31:0] seed = 32'hB74959F3;
  reg  [31:0] v;
  always #5 sys_clk = ~sys_clk;
  csl_core #(.BLINK_CYCLES(4), .LINK_ACTIVITY_LAMP_HOLD_CYCLES(8),
    .CASSETTE_WORDS(4)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .strap_pins(strap_pins),
    .periph_active(periph_active), .serial_active(serial_active),
    .cas_rd(cas_rd), .cas_addr(cas_addr), .cas_data(cas_data),
    .expins_req(expins_req), .expins_grant(expins_grant),
    .expins_refused(expins_refused), .outputs_enable(outputs_enable),
    .console_english(console_english),
    .console_expansion_flag(console_expansion_flag),
    .serial_frame(serial_frame), .run_lamp(run_lamp),
    .error_lamp(error_lamp), .output_inhibit_lamp(output_inhibit_lamp),
    .link_activity_lamp(link_activity_lamp));
  csl_cas_model i_cas (.sys_clk(sys_clk), .cas_rd(cas_rd),
    .cas_addr(cas_addr), .cas_data(cas_data), .rd_count(cas_count));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task complete_run;
    begin
      if (err_count == 0 && samples_checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [5:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
    end
  endtask
  task rd(input [5:0] a);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata;
    end
  endtask
  task settle;
    begin
      repeat (3) @(posedge sys_clk);
      #1;
    end
  endtask
  task boot(input [5:0] s);
    begin
      @(posedge sys_clk);
      rst_n      <= 1'b0;
      strap_pins <= s;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (40) @(posedge sys_clk);
    end
  endtask
  // Counts lamp changes over sixteen cycles: error lamp or link lamp.
  task togs(input sel);
    reg last;
    begin
      n = 0;
      last = sel ? link_activity_lamp : error_lamp;
      repeat (16) begin
        @(posedge sys_clk);
        #1;
        if ((sel ? link_activity_lamp : error_lamp) !== last)
          n = n + 1;
        last = sel ? link_activity_lamp : error_lamp;
      end
    end
  endtask
  task exp_pulse;
    begin
      @(posedge sys_clk);
      expins_req <= 1'b1;
      @(posedge sys_clk);
      expins_req <= 1'b0;
      #1;
    end
  endtask
  initial begin
    boot(6'h00);
    rd(6'h04);
    chk(v, 32'h0);
    chk({console_english, console_expansion_flag}, 2'b00);
    chk(cas_count, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      seed = xs(seed);
      wr(6'h0C, {24'h0, seed[7:0]});
      rd(6'h10);
      chk(v, {24'h0, seed[7:0]});
      wr(6'h14, {24'h0, seed[15:8]});
      wr(6'h18, {16'h0, seed[31:16]});
      rd(6'h18);
      chk(v, {16'h0, seed[31:16]});
    end
    exp_pulse;
    chk({expins_grant, expins_refused}, 2'b01);
    rd(6'h3C);
    chk(v, 32'h0);
    rd(6'h05);
    chk(v, 32'h0);
    wr(6'h00, 32'h1);
    settle;
    chk({run_lamp, outputs_enable}, 2'b11);
    wr(6'h00, 32'h3);
    togs(1'b0);
    chk(n >= 3, 1'b1);
    chk(run_lamp, 1'b1);
    wr(6'h00, 32'h9);
    settle;
    chk({output_inhibit_lamp, outputs_enable}, 2'b10);
    wr(6'h00, 32'h5);
    settle;
    togs(1'b0);
    chk(n, 0);
    chk({error_lamp, run_lamp, outputs_enable}, 3'b100);
    wr(6'h00, 32'h11);
    settle;
    chk(run_lamp, 1'b1);
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge sys_clk);
      {periph_active, serial_active} <= i ? 2'b10 : 2'b01;
      togs(1'b1);
      chk(n >= 3, 1'b1);
      @(posedge sys_clk);
      {periph_active, serial_active} <= 2'b00;
      repeat (20) @(posedge sys_clk);
      #1 chk(link_activity_lamp, 1'b0);
    end
    boot(6'h3F);
    rd(6'h04);
    chk(v, 32'h3F);
    chk({console_english, console_expansion_flag}, 2'b11);
    rd(6'h10);
    chk(v, 32'h75);
    chk(serial_frame, 8'h75);
    chk(cas_count, 8'h04);
    wr(6'h14, 32'h2);
    rd(6'h18);
    chk(v, 32'hC502);
    wr(6'h18, 32'h1234);
    rd(6'h18);
    chk(v, 32'hC502);
    rd(6'h08);
    chk(v[5], 1'b1);
    exp_pulse;
    chk({expins_grant, expins_refused}, 2'b10);
    @(posedge sys_clk);
    strap_pins <= 6'h00;
    repeat (8) @(posedge sys_clk);
    #1 chk({console_english, console_expansion_flag}, 2'b11);
    // A random strap word catches swapped or misplaced strap bits.
    seed = xs(seed);
    boot(seed[5:0]);
    rd(6'h04);
    chk(v, {26'h0, seed[5:0]});
    chk({console_english, console_expansion_flag},
        {seed[2], seed[5]});
    rd(6'h10);
    chk(v, seed[4] ? 32'h75 : 32'h0);
    chk(cas_count, seed[1] ? 8'h08 : 8'h04);
    exp_pulse;
    chk({expins_grant, expins_refused}, {seed[3], !seed[3]});
    complete_run;
  end
  initial begin
    #50000;
    err_count = err_count + 1;
    complete_run;
  end
endmodule // csl_core_tb

// >>> core/csl_blinker.v
// Free-running square wave used to flash the lamps.
// Assumes sys_clk at the rate set in the constants header.
`timescale 1ns/1ps
`include "csl_map.vh"
module csl_blinker #(
  parameter integer HALF_CYCLES = 25000000
) (
  // Clock and reset.
  input  wire sys_clk,
  input  wire rst_n,
  // Flash phase.
  output reg  phase_reg
);
  reg [31:0] cnt_reg;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg   <= 32'h00000000;
      phase_reg <= 1'b0;
    end else if (cnt_reg >= HALF_CYCLES - 1) begin
      cnt_reg   <= 32'h00000000;
      phase_reg <= ~phase_reg;
    end else begin
      cnt_reg <= cnt_reg + 32'h00000001;
    end
  end
endmodule // csl_blinker

// >>> core/csl_core.v
// Strap configuration and status lamps of the controller CPU.
// Assumes straps and link activity come from pins; bus on sys_clk.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "csl_map.vh"
module csl_core #(
  parameter integer BLINK_CYCLES =
    (`CSL_CLK_HZ / 1000) * `CSL_BLINK_MS / 2,
  parameter integer LINK_ACTIVITY_LAMP_HOLD_CYCLES =
    (`CSL_CLK_HZ / 1000) * `CSL_LINK_ACTIVITY_LAMP_HOLD_MS,
  parameter integer CASSETTE_WORDS = 256
) (
  // Clock and reset.
  input  wire        sys_clk,
  input  wire        rst_n,
  // Register port.
  input  wire [5:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Strap and activity pins.
  input  wire [5:0]  strap_pins,
  input  wire        periph_active,
  input  wire        serial_active,
  // Cassette read port.
  output reg         cas_rd,
  output reg  [7:0]  cas_addr,
  input  wire [15:0] cas_data,
  // Output unit enable and modes.
  input  wire        expins_req,
  output reg         expins_grant,
  output reg         expins_refused,
  output reg         outputs_enable,
  output reg         console_english,
  output reg         console_expansion_flag,
  output reg  [7:0]  serial_frame,
  // Lamps.
  output reg         run_lamp,
  output reg         error_lamp,
  output reg         output_inhibit_lamp,
  output reg         link_activity_lamp
);
  // Synchronisers for pin inputs.
  reg  [5:0]  strap_s1_reg;
  reg  [5:0]  strap_s2_reg;
  reg  [1:0]  act_s1_reg;
  reg  [1:0]  act_s2_reg;
  reg  [5:0]  strap_reg;
  reg         sampled_reg;
  reg  [7:0]  ctrl_reg;
  reg  [7:0]  sercfg_reg;
  reg  [7:0]  upm_addr_reg;
  reg         fatal_reg;
  reg         loading_reg;
  reg         loaded_reg;
  reg         cas_pend_reg;
  reg  [7:0]  load_idx_reg;
  reg         wrblk_reg;
  reg  [1:0]  settle_reg;
  reg  [31:0] rd_hold_reg;
  reg  [31:0] link_activity_lamp_cnt_reg;
  wire        blink;
  wire [15:0] upm_q;
  wire        upm_we;
  wire [7:0]  upm_wa;
  wire [15:0] upm_wd;
  wire        sw_upm_wr;
  wire        running;
  wire        nferr;

  // Decode of a word-aligned register index.
  function hit;
    input [5:0] addr;
    input [3:0] idx;
    begin
      hit = (addr[1:0] == 2'h0) && (addr[5:2] == idx);
    end
  endfunction

  csl_blinker #(
    .HALF_CYCLES (BLINK_CYCLES)
  ) u_blink (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .phase_reg (blink)
  );

  // Software writes to user memory are dropped while strap zero is on.
  assign sw_upm_wr = reg_wr && hit(reg_addr, `CSL_IDX_UPM_DATA);
  assign upm_we = loading_reg ? cas_pend_reg
                : (sw_upm_wr && !strap_reg[`CSL_STRAP_WPROT]);
  assign upm_wa = loading_reg ? load_idx_reg : upm_addr_reg;
  assign upm_wd = loading_reg ? cas_data : reg_wdata[15:0];

  csl_upm_ram u_upm (
    .sys_clk (sys_clk),
    .wr_en   (upm_we),
    .wr_addr (upm_wa),
    .wr_data (upm_wd),
    .rd_addr (upm_addr_reg),
    .rd_data (upm_q)
  );

  assign running = sampled_reg && !loading_reg && !fatal_reg &&
                   ctrl_reg[`CSL_CTRL_RUN];
  assign nferr = ctrl_reg[`CSL_CTRL_NFERR];

  // Pin synchronisers.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1_reg <= `CSL_STRAPS_OFF;
      strap_s2_reg <= `CSL_STRAPS_OFF;
      act_s1_reg   <= 2'h0;
      act_s2_reg   <= 2'h0;
    end else begin
      strap_s1_reg <= strap_pins;
      strap_s2_reg <= strap_s1_reg;
      act_s1_reg   <= {serial_active, periph_active};
      act_s2_reg   <= act_s1_reg;
    end
  end

  // Straps are caught once after reset release and held until next reset.
  // The capture waits for both sync stages to fill; any earlier it would
  // take their reset value instead of the pins.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_reg   <= `CSL_STRAPS_OFF;
      sampled_reg <= 1'b0;
      settle_reg  <= 2'h0;
    end else if (!sampled_reg) begin
      if (settle_reg == `CSL_STRAP_SETTLE) begin
        strap_reg   <= strap_s2_reg;
        sampled_reg <= 1'b1;
      end else begin
        settle_reg  <= settle_reg + 2'h1;
      end
    end
  end

  // Start-up cassette copy; cassette data stand one cycle after cas_rd.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      loading_reg  <= 1'b0;
      loaded_reg   <= 1'b0;
      cas_pend_reg <= 1'b0;
      load_idx_reg <= 8'h00;
      cas_rd       <= 1'b0;
      cas_addr     <= 8'h00;
    end else begin
      cas_pend_reg <= cas_rd;
      cas_rd       <= 1'b0;
      if (!sampled_reg) begin
        loading_reg <= 1'b0;
      end else if (!loaded_reg && !loading_reg) begin
        if (strap_reg[`CSL_STRAP_AUTOLD]) begin
          loading_reg <= 1'b1;
          cas_rd      <= 1'b1;
          cas_addr    <= 8'h00;
        end else begin
          loaded_reg  <= 1'b1;
        end
        load_idx_reg <= 8'h00;
      end else if (loading_reg && cas_pend_reg) begin
        if (load_idx_reg == CASSETTE_WORDS - 1) begin
          loading_reg <= 1'b0;
          loaded_reg  <= 1'b1;
        end else begin
          load_idx_reg <= load_idx_reg + 8'h01;
          cas_addr     <= load_idx_reg + 8'h01;
          cas_rd       <= 1'b1;
        end
      end
    end
  end

  // Register writes; a fatal error latches until software clears it.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg     <= `CSL_CTRL_RESET;
      sercfg_reg   <= `CSL_SERCFG_RESET;
      upm_addr_reg <= 8'h00;
      fatal_reg    <= 1'b0;
      wrblk_reg    <= 1'b0;
    end else begin
      if (reg_wr && hit(reg_addr, `CSL_IDX_CTRL)) begin
        ctrl_reg <= reg_wdata[7:0];
      end
      if (reg_wr && hit(reg_addr, `CSL_IDX_SERCFG)) begin
        sercfg_reg <= reg_wdata[7:0];
      end
      if (reg_wr && hit(reg_addr, `CSL_IDX_UPM_ADDR)) begin
        upm_addr_reg <= reg_wdata[7:0];
      end
      // Set wins over the clear in the same cycle.
      if (reg_wr && hit(reg_addr, `CSL_IDX_CTRL) &&
          reg_wdata[`CSL_CTRL_FATAL]) begin
        fatal_reg <= 1'b1;
      end else if (reg_wr && hit(reg_addr, `CSL_IDX_CTRL) &&
                   reg_wdata[`CSL_CTRL_CLRERR]) begin
        fatal_reg <= 1'b0;
      end
      if (sw_upm_wr && strap_reg[`CSL_STRAP_WPROT]) begin
        wrblk_reg <= 1'b1;
      end else if (reg_rd && hit(reg_addr, `CSL_IDX_STATUS)) begin
        wrblk_reg <= 1'b0;
      end
    end
  end

  // Read data stand in the cycle after the strobe only.
  always @* begin
    rd_hold_reg = 32'h00000000;
    if (hit(reg_addr, `CSL_IDX_CTRL)) begin
      rd_hold_reg = {24'h000000, ctrl_reg[7:5], 1'b0, ctrl_reg[3],
                     fatal_reg, ctrl_reg[1:0]};
    end else if (hit(reg_addr, `CSL_IDX_STRAP)) begin
      rd_hold_reg = {26'h0000000, strap_reg};
    end else if (hit(reg_addr, `CSL_IDX_STATUS)) begin
      rd_hold_reg = {25'h0000000, !strap_reg[`CSL_STRAP_EXPINS],
                     wrblk_reg, loaded_reg, loading_reg, fatal_reg,
                     nferr, running};
    end else if (hit(reg_addr, `CSL_IDX_SERCFG)) begin
      rd_hold_reg = {24'h000000, sercfg_reg};
    end else if (hit(reg_addr, `CSL_IDX_FRAME)) begin
      rd_hold_reg = {24'h000000, serial_frame};
    end else if (hit(reg_addr, `CSL_IDX_UPM_ADDR)) begin
      rd_hold_reg = {24'h000000, upm_addr_reg};
    end
  end

  // User memory data come straight from the memory's read register.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd && hit(reg_addr, `CSL_IDX_UPM_DATA)) begin
      reg_rdata <= {16'h0000, upm_q};
    end else if (reg_rd) begin
      reg_rdata <= rd_hold_reg;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // Activity is stretched; a short burst lights the lamp only if a blink high phase falls within its hold time.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_activity_lamp_cnt_reg <= 32'h00000000;
    end else if (act_s2_reg != 2'h0) begin
      link_activity_lamp_cnt_reg <= LINK_ACTIVITY_LAMP_HOLD_CYCLES;
    end else if (link_activity_lamp_cnt_reg != 32'h00000000) begin
      link_activity_lamp_cnt_reg <= link_activity_lamp_cnt_reg - 32'h00000001;
    end
  end

  // Mode outputs and lamps, all registered.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      expins_grant           <= 1'b0;
      expins_refused         <= 1'b0;
      outputs_enable         <= 1'b0;
      console_english        <= 1'b0;
      console_expansion_flag <= 1'b0;
      serial_frame           <= `CSL_SERCFG_RESET;
      run_lamp               <= 1'b0;
      error_lamp             <= 1'b0;
      output_inhibit_lamp    <= 1'b0;
      link_activity_lamp     <= 1'b0;
    end else begin
      console_english <= strap_reg[`CSL_STRAP_ENGLISH];
      expins_grant    <= expins_req &&
                         strap_reg[`CSL_STRAP_EXPINS];
      expins_refused  <= expins_req &&
                         !strap_reg[`CSL_STRAP_EXPINS];
      serial_frame    <= strap_reg[`CSL_STRAP_FORCED] ?
                         `CSL_FRAME_FORCED
                         : sercfg_reg;
      console_expansion_flag <= strap_reg[`CSL_STRAP_CONEXP];
      run_lamp        <= running;
      error_lamp      <= fatal_reg ? 1'b1
                         : (nferr && blink);
      output_inhibit_lamp <= ctrl_reg[`CSL_CTRL_INHIBIT];
      outputs_enable  <= running &&
                         !ctrl_reg[`CSL_CTRL_INHIBIT];
      link_activity_lamp <= (link_activity_lamp_cnt_reg != 32'h00000000) &&
                            blink;
    end
  end
endmodule // csl_core

// >>> core/csl_map.vh
// Constants for the strap configuration and status lamp block.
// Assumes a 100 MHz system clock; included by its bare name.
`ifndef CSL_MAP_VH
`define CSL_MAP_VH

// Register indices, each at byte address four times the index.
`define CSL_IDX_CTRL      4'h0
`define CSL_IDX_STRAP     4'h1
`define CSL_IDX_STATUS    4'h2
`define CSL_IDX_SERCFG    4'h3
`define CSL_IDX_FRAME     4'h4
`define CSL_IDX_UPM_ADDR  4'h5
`define CSL_IDX_UPM_DATA  4'h6

// Control register fields.
`define CSL_CTRL_RUN      0
`define CSL_CTRL_NFERR    1
`define CSL_CTRL_FATAL    2
`define CSL_CTRL_INHIBIT  3
`define CSL_CTRL_CLRERR   4
`define CSL_CTRL_RESET    8'h00

// Status register fields.
`define CSL_ST_RUNNING    0
`define CSL_ST_NFERR      1
`define CSL_ST_FATAL      2
`define CSL_ST_LOADING    3
`define CSL_ST_LOADED     4
`define CSL_ST_WRBLOCKED  5
`define CSL_ST_EXPREFUSED 6

// Strap positions in the strap word.
`define CSL_STRAP_WPROT   0
`define CSL_STRAP_AUTOLD  1
`define CSL_STRAP_ENGLISH 2
`define CSL_STRAP_EXPINS  3
`define CSL_STRAP_FORCED  4
`define CSL_STRAP_CONEXP  5
`define CSL_STRAPS_OFF    6'h00
`define CSL_STRAP_SETTLE  2'h2

// Forced serial format: {baud code 4, parity 2, stop 1, data 1}.
`define CSL_FRAME_FORCED  8'h75
`define CSL_SERCFG_RESET  8'h00

// Timing.
`define CSL_CLK_HZ        100000000
`define CSL_BLINK_MS      250
`define CSL_LINK_ACTIVITY_LAMP_HOLD_MS  50

// Memory geometry.
`define CSL_UPM_AW        8
`define CSL_UPM_DW        16

`endif

// >>> core/csl_upm_ram.v
// Small user program memory with registered read data.
// Assumes a single clock; write blocking is done by the caller.
`timescale 1ns/1ps
`include "csl_map.vh"
module csl_upm_ram (
  // Clock.
  input  wire                    sys_clk,
  // Write port.
  input  wire                    wr_en,
  input  wire [`CSL_UPM_AW-1:0]  wr_addr,
  input  wire [`CSL_UPM_DW-1:0]  wr_data,
  // Read port.
  input  wire [`CSL_UPM_AW-1:0]  rd_addr,
  output reg  [`CSL_UPM_DW-1:0]  rd_data
);
  reg [`CSL_UPM_DW-1:0] mem [0:(1<<`CSL_UPM_AW)-1];

  always @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // csl_upm_ram
